// ### src/pesc_params.svh
`ifndef PESC_PARAMS_SVH
`define PESC_PARAMS_SVH
// Clock and acknowledge window
`define PESC_CLK_HZ 50000000
`define PESC_ACK_WINDOW_S 5
`define PESC_ACK_CYCLES (`PESC_ACK_WINDOW_S * `PESC_CLK_HZ)
// Voltage code layout in run/standby registers
`define PESC_VSEL_BIT 5
`define PESC_DAC_W 5
// Power-on values of the serial-port registers
`define PESC_RUN_RST 8'h39
`define PESC_STB_RST 8'h19
`endif

// ### src/pesc_pkg.sv
package pesc_pkg;
  typedef struct packed {
    logic ldo_four;
    logic ldo_three;
    logic buck_four;
    logic buck_three;
  } pesc_en_t;
  typedef enum logic [1:0] {
    PESC_OFF,
    PESC_WAIT_ACK,
    PESC_ON
  } pesc_wake_st_t;
endpackage

// ### src/pesc_ctrl.sv
`timescale 1ns/1ps
`include "pesc_params.svh"
module pesc_ctrl #(
  parameter int NUM_BUCK = 4,
  parameter bit HAS_LDO_FOUR_PIN = 1'b1,
  parameter int unsigned ACK_CYCLES = `PESC_ACK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Enable pins
  input wire pesc_pkg::pesc_en_t enable_in,
  // Host handshake and pushbutton
  input wire logic voltage_standby_in,
  input wire logic host_power_ack_in,
  input wire logic button_pressed_in,
  // Serial-port supply monitor, high while above 1 V
  input wire logic serial_port_supply_ok_in,
  // Register file write port from the serial-port logic
  input wire logic reg_we,
  input wire logic reg_sel_standby,
  input wire logic [1:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  // Outputs
  output pesc_pkg::pesc_en_t regulator_on,
  output logic [NUM_BUCK*`PESC_DAC_W-1:0] buck_dac_code,
  output logic wake_out,
  output logic wake_oe
);
  import pesc_pkg::*;

  // Every pin input crosses two flip-flops before logic reads it
  // Reset clears them, so the first edges after reset see all pins low
  localparam int NSYNC = $bits(pesc_en_t) + 4;
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync1_nxt;
  logic [NSYNC-1:0] sync2_nxt;
  // Order must match the unpacking below
  assign pins = {
    enable_in,
    voltage_standby_in,
    host_power_ack_in,
    button_pressed_in,
    serial_port_supply_ok_in
  };
  always_comb begin
    sync1_nxt = pins;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // Synchronised pin levels
  pesc_en_t en_s;
  logic stb_s;
  logic ack_s;
  logic btn_s;
  logic supply_ok_s;
  assign {en_s, stb_s, ack_s, btn_s, supply_ok_s} = sync2_r;

  // Run and standby voltage registers
  logic [7:0] run_r [NUM_BUCK];
  logic [7:0] stb_r [NUM_BUCK];
  logic [7:0] run_nxt [NUM_BUCK];
  logic [7:0] stb_nxt [NUM_BUCK];

  function automatic logic [`PESC_DAC_W-1:0] pick_code(
    input logic standby,
    input logic [7:0] run_v,
    input logic [7:0] stb_v
  );
    logic use_stb;
    // Standby pin overrides the per-regulator selection bit
    use_stb = standby | run_v[`PESC_VSEL_BIT];
    if (use_stb) begin
      pick_code = stb_v[`PESC_DAC_W-1:0];
    end else begin
      pick_code = run_v[`PESC_DAC_W-1:0];
    end
  endfunction

  // Writes are ignored while the port supply is low
  // A supply dip wins over a write in the same cycle
  always_comb begin
    for (int i = 0; i < NUM_BUCK; i++) begin
      run_nxt[i] = run_r[i];
      stb_nxt[i] = stb_r[i];
      if (!supply_ok_s) begin
        run_nxt[i] = `PESC_RUN_RST;
        stb_nxt[i] = `PESC_STB_RST;
      end else if (reg_we && reg_idx == i[1:0]) begin
        if (reg_sel_standby) stb_nxt[i] = reg_wdata;
        else run_nxt[i] = reg_wdata;
      end
    end
  end

  logic [NUM_BUCK*`PESC_DAC_W-1:0] dac_nxt;
  // Codes come from the next register values, so the write edge
  // updates the regulator with no extra cycle of lag
  genvar g;
  generate
    for (g = 0; g < NUM_BUCK; g++) begin : g_buck
      assign dac_nxt[g*`PESC_DAC_W +: `PESC_DAC_W] =
        pick_code(stb_s, run_nxt[g], stb_nxt[g]);
    end
  endgenerate

  // One process owns the whole code bus and all register words
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_BUCK; i++) begin
        run_r[i] <= `PESC_RUN_RST;
        stb_r[i] <= `PESC_STB_RST;
      end
      buck_dac_code <= '0;
    end else begin
      for (int i = 0; i < NUM_BUCK; i++) begin
        run_r[i] <= run_nxt[i];
        stb_r[i] <= stb_nxt[i];
      end
      buck_dac_code <= dac_nxt;
    end
  end

  // Regulator enables follow their pins, ldo_four only while HAS_LDO_FOUR_PIN is set
  // Three edges of lag: two synchroniser stages and the output flop
  pesc_en_t on_nxt;
  always_comb begin
    on_nxt.ldo_four = HAS_LDO_FOUR_PIN & en_s.ldo_four;
    on_nxt.ldo_three = en_s.ldo_three;
    on_nxt.buck_four = en_s.buck_four;
    on_nxt.buck_three = en_s.buck_three;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) regulator_on <= '0;
    else regulator_on <= on_nxt;
  end

  // Wake handshake
  pesc_wake_st_t st_r;
  pesc_wake_st_t st_nxt;
  // Wide enough for the full window at the system clock
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic btn_prev_r;
  logic btn_prev_nxt;
  logic btn_rise;
  logic wake_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    btn_prev_nxt = btn_s;
    // Only a new press counts, so a held button cannot re-wake
    btn_rise = btn_s & ~btn_prev_r;
    unique case (st_r)
      PESC_OFF: begin
        // A retry always restarts the window from zero
        cnt_nxt = '0;
        if (ack_s) st_nxt = PESC_ON;
        else if (btn_rise) st_nxt = PESC_WAIT_ACK;
      end
      PESC_WAIT_ACK: begin
        // Host gets the full window before power is pulled
        cnt_nxt = cnt_r + 32'h1;
        if (ack_s) st_nxt = PESC_ON;
        else if (cnt_r >= ACK_CYCLES - 1) st_nxt = PESC_OFF;
      end
      PESC_ON: begin
        // Losing the acknowledge drops wake at once
        if (!ack_s) st_nxt = PESC_OFF;
      end
      default: begin
        // Unused state code falls back to off
        st_nxt = PESC_OFF;
      end
    endcase
    wake_nxt = (st_nxt != PESC_OFF);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= PESC_OFF;
      cnt_r <= '0;
      btn_prev_r <= 1'b0;
      wake_oe <= 1'b1;
      wake_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      btn_prev_r <= btn_prev_nxt;
      // Open drain: pull low while off, release while awake
      wake_oe <= !wake_nxt;
      wake_out <= 1'b0;
    end
  end
endmodule

// ### verif/pesc_host_model.sv
`timescale 1ns/1ps
module pesc_host_model (
  input wire logic clk,
  input wire logic wake_oe,
  input wire logic [7:0] ack_delay,
  input wire logic drop,
  output logic ack
);
  int n = 0;
  logic ack_r = 1'b0;
  assign ack = ack_r;
  // A delay past the window models a host that never confirms
  always @(posedge clk) begin
    n <= wake_oe ? 0 : n + 1;
    if (drop)
      ack_r <= #1 1'b0;
    else if (!wake_oe && n == ack_delay)
      ack_r <= #1 1'b1;
  end
endmodule

// ### verif/pesc_ctrl_properties.sv
`timescale 1ns/1ps
module pesc_ctrl_props #(parameter int unsigned ACK_CYCLES = 50) (
  input wire logic clk, reset_n, voltage_standby_in, host_power_ack_in,
  input wire logic button_pressed_in, serial_port_supply_ok_in, reg_we,
  input wire logic reg_sel_standby, wake_oe,
  input wire logic [1:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  input wire logic [19:0] buck_dac_code,
  input wire pesc_pkg::pesc_en_t enable_in, regulator_on
);
  localparam int LIM = ACK_CYCLES + 5;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_enable_follow: assert property (
    $changed(enable_in) |-> ##3 regulator_on == $past(enable_in, 3))
    else $error("regulator enable lag");
  a_run_select: assert property (
    (!voltage_standby_in && serial_port_supply_ok_in)[*4]
    ##0 (reg_we && !reg_sel_standby && reg_idx == 2'h0 && !reg_wdata[5])
    |=> buck_dac_code[4:0] == $past(reg_wdata[4:0]))
    else $error("run code not used");
  a_standby_force: assert property (
    (voltage_standby_in && serial_port_supply_ok_in)[*4]
    ##0 (reg_we && reg_sel_standby && reg_idx == 2'h0)
    |=> buck_dac_code[4:0] == $past(reg_wdata[4:0]))
    else $error("standby code not forced");
  a_supply_reset: assert property (
    !serial_port_supply_ok_in[*6] |-> buck_dac_code == {4{5'h19}})
    else $error("port registers not reset");
  a_ack_wake: assert property (
    host_power_ack_in[*5] |-> !wake_oe) else $error("ack did not wake");
  a_ack_drop: assert property (
    host_power_ack_in[*4] ##1 !host_power_ack_in[*5] |-> wake_oe)
    else $error("ack low kept wake");
  a_button_wake: assert property (
    $rose(button_pressed_in) && wake_oe |-> ##3 !wake_oe)
    else $error("button did not wake");
  a_window_expire: assert property (
    $fell(wake_oe) && !host_power_ack_in
    |-> ##[1:LIM] (wake_oe || host_power_ack_in))
    else $error("ack window did not expire");
endmodule
bind pesc_ctrl pesc_ctrl_props #(.ACK_CYCLES(ACK_CYCLES)) u_props (
  .clk(clk), .reset_n(reset_n), .voltage_standby_in(voltage_standby_in),
  .host_power_ack_in(host_power_ack_in), .reg_we(reg_we),
  .button_pressed_in(button_pressed_in), .reg_sel_standby(reg_sel_standby),
  .serial_port_supply_ok_in(serial_port_supply_ok_in), .wake_oe(wake_oe),
  .reg_idx(reg_idx), .reg_wdata(reg_wdata), .buck_dac_code(buck_dac_code),
  .enable_in(enable_in), .regulator_on(regulator_on));

// ### verif/pesc_ctrl_test.sv
`timescale 1ns/1ps
module pesc_ctrl_test;
  import pesc_pkg::*;
  logic clk = 0, reset_n = 0, stb = 0, btn = 0, sok = 1, we = 0, sel = 0;
  logic drop = 0, ack, wake, woe;
  logic [1:0] idx = 0;
  logic [7:0] wd = 0, dly = 8'h05;
  logic [19:0] code;
  pesc_en_t en = '0, on;
  int error_cnt = 0, check_count = 0;
  always #10 clk = ~clk;
  pesc_ctrl #(.ACK_CYCLES(50)) dut (.clk(clk), .reset_n(reset_n),
    .enable_in(en), .voltage_standby_in(stb), .host_power_ack_in(ack),
    .button_pressed_in(btn), .serial_port_supply_ok_in(sok), .reg_we(we),
    .reg_sel_standby(sel), .reg_idx(idx), .reg_wdata(wd),
    .regulator_on(on), .buck_dac_code(code), .wake_out(wake), .wake_oe(woe));
  pesc_host_model host (.clk(clk), .wake_oe(woe), .ack_delay(dly),
    .drop(drop), .ack(ack));
  task cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(string nm, logic [19:0] seen, logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task t_en;
    for (int i = 0; i < 16; i += 5) begin
      en = pesc_en_t'(i[3:0]);
      cyc(4);
      chk("enables", 20'(on), 20'(i[3:0]));
    end
    $display("enable test done");
  endtask
  task t_dac;
    we = 1;
    wd = 8'h0A;
    cyc(1);
    we = 0;
    cyc(1);
    chk("run code", 20'(code[4:0]), 20'h0A);
    stb = 1;
    cyc(5);
    sel = 1;
    we = 1;
    wd = 8'h03;
    cyc(1);
    we = 0;
    cyc(1);
    chk("standby code", 20'(code[4:0]), 20'h03);
    // Supply loss must undo the write just made
    sok = 0;
    cyc(8);
    sok = 1;
    stb = 0;
    cyc(5);
    chk("reset codes", code, {4{5'h19}});
    sel = 0;
    we = 1;
    wd = 8'h21;
    cyc(1);
    we = 0;
    cyc(1);
    chk("bit5 picks standby", 20'(code[4:0]), 20'h19);
    $display("dac test done");
  endtask
  task t_wake;
    btn = 1;
    cyc(2);
    btn = 0;
    cyc(60);
    chk("wake held", 20'(woe), 20'h0);
    drop = 1;
    cyc(6);
    chk("wake dropped", 20'(woe), 20'h1);
    dly = 8'hFF;
    drop = 0;
    btn = 1;
    cyc(2);
    btn = 0;
    cyc(3);
    chk("wake up", 20'(woe), 20'h0);
    chk("wake data", 20'(wake), 20'h0);
    cyc(60);
    chk("window expiry", 20'(woe), 20'h1);
    $display("wake test done");
  endtask
  initial begin
    cyc(5);
    reset_n = 1;
    cyc(3);
    t_en;
    t_dac;
    t_wake;
    complete_run;
  end
endmodule
